// ===== sia_host_model.sv
// host controller model: drives the sequence terminals with the wiring sense
`timescale 1ns/100ps
`default_nettype none
module sia_host_model
	import sia_pkg::*;
(
	// requested function state and wiring
	input  wire logic [SIA_NUM_TERM-1:0] act,
	input  wire logic                    source_wiring,
	// terminal levels
	output logic      [SIA_NUM_TERM-1:0] pin
);
	// sink closes the contact to 0 v, source drives 24 v; terminals are never left floating
	assign pin = source_wiring ? act : ~act;
endmodule : sia_host_model
`default_nettype wire

// ===== sia_in_select.sv
// input selector: maps one function to a terminal or a constant
`timescale 1ns/100ps
`default_nettype none
module sia_in_select
	import sia_pkg::*;
(
	// selector and terminals
	input  wire logic [3:0]              sel,
	input  wire logic [SIA_NUM_TERM-1:0] term_act,
	// result
	output logic                         active
);
	wire logic [3:0] inv_idx = sel - SIA_SEL_INV_BASE;
	wire logic       pick_n  = (sel <= SIA_SEL_TERM_MAX) ? term_act[sel[2:0]] : 1'b0;
	wire logic       pick_i  = (sel >= SIA_SEL_INV_BASE) ? ~term_act[inv_idx[2:0]] : 1'b0;
	// 9..f maps onto terminals 0..6 with sense turned round
	assign active = (sel == SIA_SEL_ON) ? 1'b1 :
	                (sel == SIA_SEL_OFF) ? 1'b0 :
	                (sel <= SIA_SEL_TERM_MAX) ? pick_n : pick_i;
endmodule : sia_in_select
`default_nettype wire

// ===== sia_out_router.sv
// output router: or-combines functions per circuit and applies polarity
`timescale 1ns/100ps
`default_nettype none
module sia_out_router
	import sia_pkg::*;
(
	// routing carrier
	sia_route_if.rtr rt
);
	// per circuit or of every function whose selector names it
	genvar c;
	generate
		for (c = 0; c < SIA_NUM_OUT; c++)
		begin : g_circ
			logic [SIA_NUM_OFUNC-1:0] hit;
			genvar f;
			for (f = 0; f < SIA_NUM_OFUNC; f++)
			begin : g_f
				assign hit[f] = rt.func[f] &&
					(rt.sel[f*SIA_DIGIT_W +: SIA_DIGIT_W] == 4'(c + 1));
			end
			// polarity applied after the or so inversion is per circuit
			assign rt.circ[c] = (|hit) ^ rt.pol[c];
		end
	endgenerate
endmodule : sia_out_router
`default_nettype wire

// ===== sia_pkg.sv
// package: allocation word layouts, terminal selector codes and factory values
package sia_pkg;
	localparam int unsigned SIA_NUM_TERM       = 7;
	localparam int unsigned SIA_NUM_OUT        = 3;
	localparam int unsigned SIA_NUM_OFUNC      = 9;
	localparam int unsigned SIA_NUM_IFUNC      = 2;
	localparam int unsigned SIA_DIGIT_W        = 4;
	localparam int unsigned SIA_WORD_W         = 16;
	// digit positions inside the allocation words
	localparam int unsigned SIA_IA_FREE_DIG    = 0;
	localparam int unsigned SIA_IA_SON_DIG     = 1;
	localparam int unsigned SIA_IB_FCL_DIG     = 2;
	// input selector codes
	localparam logic [3:0]  SIA_SEL_TERM_MAX   = 4'h6;
	localparam logic [3:0]  SIA_SEL_ON         = 4'h7;
	localparam logic [3:0]  SIA_SEL_OFF        = 4'h8;
	localparam logic [3:0]  SIA_SEL_INV_BASE   = 4'h9;
	localparam logic [3:0]  SIA_FREE_EN        = 4'h1;
	// output selector codes: 0 unused, 1..3 circuit
	localparam logic [3:0]  SIA_OSEL_NONE      = 4'h0;
	// reset values of the allocation words
	localparam logic [15:0] SIA_IA_RST         = 16'h2100;
	localparam logic [15:0] SIA_IB_RST         = 16'h6543;
	localparam logic [15:0] SIA_OA_RST         = 16'h3211;
	localparam logic [15:0] SIA_OB_RST         = 16'h0000;
	localparam logic [15:0] SIA_OC_RST         = 16'h0000;
	localparam logic [15:0] SIA_POL_RST        = 16'h0000;
	// output function order in the function vector
	localparam int unsigned SIA_F_POS_DONE     = 0;
	localparam int unsigned SIA_F_NEAR         = 8;
endpackage : sia_pkg

// ===== sia_route_if.sv
// interface: function vector and routing selectors between top and output router
`timescale 1ns/100ps
`default_nettype none
interface sia_route_if;
	import sia_pkg::*;
	logic [SIA_NUM_OFUNC-1:0]             func;
	logic [SIA_NUM_OFUNC*SIA_DIGIT_W-1:0] sel;
	logic [SIA_NUM_OUT-1:0]               pol;
	logic [SIA_NUM_OUT-1:0]               circ;
	modport top (output func, output sel, output pol, input circ);
	modport rtr (input func, input sel, input pol, output circ);
endinterface : sia_route_if
`default_nettype wire

// ===== sia_top.sv
// top: sequence input allocation, output allocation and polarity control
// Contract
// - output selector 1-3 picks circuit, 0 unused
// - shared output circuit carries or of functions
// - functions undetected in current mode are invalid
// - word a digits route done, match, motion, ready
// - word b/c route force, speed, brake, warn, near
// - input word a digit0 one enables free allocation
// - input word a digit1 selects servo-on terminal
// - input word b digit2 selects force-limit terminal
// - edited words apply only after power cycle
// - sink wiring: low level means input active
// - monitor word shows every sequence input status
// - codes 0-6 terminal, 7 on, 8 off, 9-f inverted
`timescale 1ns/100ps
`default_nettype none
module sia_top
	import sia_pkg::*;
#(
	parameter int unsigned NUM_TERM = SIA_NUM_TERM
)
(
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	// parameter edit port (stored words)
	input  wire logic                  par_we,
	input  wire logic [2:0]            par_idx,
	input  wire logic [15:0]           par_wdata,
	output logic      [15:0]           par_rdata,
	// power-on apply strobe from the supervisor
	input  wire logic                  power_cycle,
	// control mode: high while position control is active
	input  wire logic                  pos_mode,
	// sequence input terminals of the io connector (electrical level)
	input  wire logic [NUM_TERM-1:0]   seq_in_pin,
	input  wire logic                  source_wiring,
	// functions from the drive core
	input  wire logic [SIA_NUM_OFUNC-1:0] out_func,
	// results
	output logic                       servo_on_req,
	output logic                       fwd_force_limit_input,
	output logic      [NUM_TERM-1:0]   input_status_monitor,
	output logic      [SIA_NUM_OUT-1:0] out_circuit
);
	// selector codes only reach seven terminals, so other counts are refused
	if (NUM_TERM != SIA_NUM_TERM)
	begin : g_bad_term
		$error("sia_top: terminal count must be seven");
	end

	// stored words: edits land here but do not steer the logic
	logic [15:0] st_ia_q, st_ib_q, st_oa_q, st_ob_q, st_oc_q, st_pol_q;
	// active words: loaded only on a power cycle
	logic [15:0] ia_q, ib_q, oa_q, ob_q, oc_q, pol_q;
	logic [NUM_TERM-1:0] sync1_q, sync2_q;
	logic                src1_q, src2_q;
	logic                son_q, fcl_q;
	logic [SIA_NUM_OUT-1:0] circ_q;
	logic [NUM_TERM-1:0] mon_q;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			st_ia_q  <= SIA_IA_RST;
			st_ib_q  <= SIA_IB_RST;
			st_oa_q  <= SIA_OA_RST;
			st_ob_q  <= SIA_OB_RST;
			st_oc_q  <= SIA_OC_RST;
			st_pol_q <= SIA_POL_RST;
		end
		else if (par_we)
		begin
			case (par_idx)
				3'h0: st_ia_q  <= par_wdata;
				3'h1: st_ib_q  <= par_wdata;
				3'h2: st_oa_q  <= par_wdata;
				3'h3: st_ob_q  <= par_wdata;
				3'h4: st_oc_q  <= par_wdata;
				3'h5: st_pol_q <= par_wdata;
				default: ;
			endcase
		end
	end

	// edits take effect only at a restart
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			ia_q  <= SIA_IA_RST;
			ib_q  <= SIA_IB_RST;
			oa_q  <= SIA_OA_RST;
			ob_q  <= SIA_OB_RST;
			oc_q  <= SIA_OC_RST;
			pol_q <= SIA_POL_RST;
		end
		else if (power_cycle)
		begin
			ia_q  <= st_ia_q;
			ib_q  <= st_ib_q;
			oa_q  <= st_oa_q;
			ob_q  <= st_ob_q;
			oc_q  <= st_oc_q;
			pol_q <= st_pol_q;
		end
	end

	// read back of stored words; unmapped index reads zero
	assign par_rdata = (par_idx == 3'h0) ? st_ia_q :
	                   (par_idx == 3'h1) ? st_ib_q :
	                   (par_idx == 3'h2) ? st_oa_q :
	                   (par_idx == 3'h3) ? st_ob_q :
	                   (par_idx == 3'h4) ? st_oc_q :
	                   (par_idx == 3'h5) ? st_pol_q :
	                   (par_idx == 3'h6) ? {{(16-NUM_TERM){1'b0}}, mon_q} : 16'h0000;

	// pins are asynchronous to clk_sys: two flops before use
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			sync1_q <= '1;
			sync2_q <= '1;
			src1_q  <= 1'b0;
			src2_q  <= 1'b0;
		end
		else
		begin
			sync1_q <= seq_in_pin;
			sync2_q <= sync1_q;
			src1_q  <= source_wiring;
			src2_q  <= src1_q;
		end
	end

	// sink wiring: low level is on; source wiring reverses it
	wire logic [NUM_TERM-1:0] term_act = src2_q ? sync2_q : ~sync2_q;

	// fixed allocation keeps servo-on on terminal 0, force limit on 5
	wire logic       free_en = (ia_q[SIA_IA_FREE_DIG*4 +: 4] == SIA_FREE_EN);
	wire logic [3:0] son_sel = free_en ? ia_q[SIA_IA_SON_DIG*4 +: 4] : 4'h0;
	wire logic [3:0] fcl_sel = free_en ? ib_q[SIA_IB_FCL_DIG*4 +: 4] : 4'h5;
	logic son_act, fcl_act;

	sia_in_select u_son (
		.sel      (son_sel),
		.term_act (term_act),
		.active   (son_act)
	);
	sia_in_select u_fcl (
		.sel      (fcl_sel),
		.term_act (term_act),
		.active   (fcl_act)
	);

	// mode gating: positioning-complete and near are position-only flags
	wire logic [SIA_NUM_OFUNC-1:0] mode_ok = pos_mode ? '1 :
		~((SIA_NUM_OFUNC'(1) << SIA_F_POS_DONE) | (SIA_NUM_OFUNC'(1) << SIA_F_NEAR));

	sia_route_if rt ();
	assign rt.func = out_func & mode_ok;
	// selector order: word a digits 0..3, word b digits 0..3, word c digit 0
	assign rt.sel  = {oc_q[3:0], ob_q, oa_q};
	assign rt.pol  = pol_q[SIA_NUM_OUT-1:0];

	sia_out_router u_rtr (
		.rt (rt)
	);

	// registered outputs
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			son_q  <= 1'b0;
			fcl_q  <= 1'b0;
			circ_q <= '0;
			mon_q  <= '0;
		end
		else
		begin
			son_q  <= son_act;
			fcl_q  <= fcl_act;
			circ_q <= rt.circ;
			mon_q  <= term_act;
		end
	end

	assign servo_on_req          = son_q;
	assign fwd_force_limit_input = fcl_q;
	assign out_circuit           = circ_q;
	assign input_status_monitor  = mon_q;

	// a power cycle must make an edit visible one cycle later
	apply_word_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		power_cycle |=> (oa_q == $past(st_oa_q))) else $error("allocation not applied");
	hold_word_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!power_cycle |=> $stable(oa_q)) else $error("allocation changed without restart");
	forced_on_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(son_sel == SIA_SEL_ON) |=> servo_on_req) else $error("forced on not active");
	forced_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(fcl_sel == SIA_SEL_OFF) |=> !fwd_force_limit_input) else $error("forced off active");
	sink_sense_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(!src2_q && son_sel == 4'h0) |=> (servo_on_req == !$past(sync2_q[0]))) else $error("sink sense wrong");
	pos_done_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(!pos_mode && oa_q[3:0] == 4'h1 && oa_q[15:4] == 12'h000 && ob_q == 16'h0000 && oc_q[3:0] == 4'h0 && !pol_q[0])
		|=> !out_circuit[0]) else $error("position done not invalid");
	or_merge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(rt.func[1] && oa_q[7:4] == 4'h2 && !pol_q[1]) |=> out_circuit[1]) else $error("or merge lost");
	pol_inv_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(pol_q[2] && oa_q == 16'h0000 && ob_q == 16'h0000 && oc_q[3:0] == 4'h0)
		|=> out_circuit[2]) else $error("idle circuit not inverted");
	monitor_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		1'b1 |=> (input_status_monitor == ($past(src2_q) ? $past(sync2_q) : ~$past(sync2_q))))
		else $error("monitor stale");
endmodule : sia_top
`default_nettype wire

// ===== sia_top_tb_top.sv
// testbench: allocation words, output routing, polarity and input selection
`timescale 1ns/100ps
`default_nettype none
module sia_top_tb_top;
	import sia_pkg::*;
	logic        clk_sys       = 1'b0;
	logic        rstn          = 1'b0;
	logic        par_we        = 1'b0;
	logic [2:0]  par_idx       = 3'd0;
	logic [15:0] par_wdata     = 16'h0000;
	logic        power_cycle   = 1'b0;
	logic        pos_mode      = 1'b1;
	logic        source_wiring = 1'b0;
	logic [8:0]  out_func      = 9'h000;
	logic [6:0]  act           = 7'h00;
	logic [6:0]  pin;
	logic [15:0] rdata;
	logic        son;
	logic        fcl;
	logic [6:0]  mon;
	logic [2:0]  circ;
	int          fail_count    = 0;
	int          cmp_count     = 0;

	always #25 clk_sys = ~clk_sys;

	sia_host_model host (.act(act), .source_wiring(source_wiring), .pin(pin));
	sia_top dut (.clk_sys(clk_sys), .rstn(rstn), .par_we(par_we), .par_idx(par_idx),
		.par_wdata(par_wdata), .par_rdata(rdata), .power_cycle(power_cycle),
		.pos_mode(pos_mode), .seq_in_pin(pin), .source_wiring(source_wiring),
		.out_func(out_func), .servo_on_req(son), .fwd_force_limit_input(fcl),
		.input_status_monitor(mon), .out_circuit(circ));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	// outputs lag pins by three cycles, so five is safe
	task automatic settle;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : settle

	task automatic wr(input logic [2:0] i, input logic [15:0] d);
		@(posedge clk_sys);
		par_we    <= 1'b1;
		par_idx   <= i;
		par_wdata <= d;
		@(posedge clk_sys);
		par_we    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] i, input logic [15:0] exp);
		@(posedge clk_sys);
		par_idx <= i;
		@(negedge clk_sys);
		chk(rdata, exp);
	endtask : rd

	// restart: stored words become active only here
	task automatic apply;
		@(posedge clk_sys);
		power_cycle <= 1'b1;
		@(posedge clk_sys);
		power_cycle <= 1'b0;
		settle();
	endtask : apply

	task automatic route(input logic [35:0] s);
		wr(3'd2, s[15:0]);
		wr(3'd3, s[31:16]);
		wr(3'd4, {12'h000, s[35:32]});
	endtask : route

	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		finish_test();
	end

	initial
	begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(3'd0, 16'h2100);
		rd(3'd1, 16'h6543);
		rd(3'd2, 16'h3211);
		rd(3'd5, 16'h0000);
		wr(3'd7, 16'hffff);
		rd(3'd7, 16'h0000);
		// factory inputs: servo-on on terminal 0, force limit on terminal 5
		@(posedge clk_sys) act <= 7'h20;
		settle();
		chk(16'(fcl), 16'h0001);
		chk(16'(son), 16'h0000);
		rd(3'd6, 16'h0020);
		@(posedge clk_sys) source_wiring <= 1'b1;
		settle();
		chk(16'(mon), 16'h0020);
		@(posedge clk_sys) source_wiring <= 1'b0;
		// free allocation swaps the two terminals, but only after restart
		wr(3'd0, 16'h2151);
		wr(3'd1, 16'h6043);
		settle();
		chk(16'(son), 16'h0000);
		apply();
		chk(16'(son), 16'h0001);
		chk(16'(fcl), 16'h0000);
		@(posedge clk_sys) act <= 7'h01;
		settle();
		chk(16'(fcl), 16'h0001);
		// every selector code for servo-on
		for (int k = 0; k < 16; k++)
		begin
			wr(3'd0, {8'h21, 4'(k), 4'h1});
			@(posedge clk_sys) act <= 7'h00;
			apply();
			chk(16'(son), 16'((k == 7) || (k > 8)));
			if (k != 7 && k != 8)
			begin
				@(posedge clk_sys) act <= 7'h01 << ((k < 7) ? k : k - 9);
				settle();
				chk(16'(son), 16'(k < 7));
			end
		end
		// each output function to each circuit, or unused
		for (int f = 0; f < 9; f++)
			for (int c = 0; c < 4; c++)
			begin
				route(36'(c) << (4 * f));
				@(posedge clk_sys) out_func <= 9'h001 << f;
				apply();
				chk(16'(circ), (c == 0) ? 16'h0000 : 16'h0001 << (c - 1));
			end
		// four functions share circuit one
		route(36'h0_0000_1111);
		apply();
		for (int f = 0; f < 5; f++)
		begin
			@(posedge clk_sys) out_func <= (f < 4) ? 9'h001 << f : 9'h000;
			settle();
			chk(16'(circ), 16'(f < 4));
		end
		// mode-gated functions drop out outside position control
		route(36'h1_0000_0021);
		apply();
		@(posedge clk_sys) out_func <= 9'h103;
		pos_mode <= 1'b0;
		settle();
		chk(16'(circ), 16'h0002);
		@(posedge clk_sys) pos_mode <= 1'b1;
		settle();
		chk(16'(circ), 16'h0003);
		wr(3'd5, 16'h0005);
		settle();
		chk(16'(circ), 16'h0003);
		rd(3'd5, 16'h0005);
		apply();
		chk(16'(circ), 16'h0006);
		finish_test();
	end
endmodule : sia_top_tb_top
`default_nettype wire
